// ### logic/ieb_pkg.sv
// Package: register map, field masks, state and carrier types of the interrupt enable bank.
// Notes on behaviour
// - A source flag is set whenever its peripheral event occurs, whatever its enable bit holds.
// - A set flag stays set until software clears it; hardware never clears it by itself.
// - Every implemented enable bit is read/write and is zero after any reset.
// - Unimplemented bits, bit 4 of the fifth enable register, ignore writes and read as zero.
package ieb_pkg;

  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned ADDR_W   = 8;

  typedef logic [NUM_REGS-1:0][REG_W-1:0] ieb_bank_t;
  typedef logic [NUM_REGS-1:0]            ieb_sel_t;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register map: one byte register per address.
  localparam logic [ADDR_W-1:0] ENABLE_BASE  = 8'h00;
  localparam logic [ADDR_W-1:0] FLAG_BASE    = 8'h08;
  localparam logic [ADDR_W-1:0] PENDING_BASE = 8'h10;

  localparam int unsigned SYSTEM_EVENT_IDX   = 0;
  localparam int unsigned MEASURE_ANALOG_IDX = 1;
  localparam int unsigned SERIAL_DMA1_IDX    = 2;
  localparam int unsigned TIMER0_UART1_IDX   = 3;
  localparam int unsigned LOGIC_TIMER_IDX    = 4;
  localparam int unsigned I2C2_DMA2_IDX      = 5;
  localparam int unsigned TIMER3_UART2_IDX   = 6;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Field positions of selected enable bits.
  localparam int unsigned PIN_CHANGE_IRQ_EN     = 7;
  localparam int unsigned CHECKSUM_IRQ_EN       = 6;
  localparam int unsigned MEMORY_SCANNER_IRQ_EN = 5;
  localparam int unsigned NONVOLATILE_IRQ_EN    = 4;
  localparam int unsigned CLOCK_SWITCH_IRQ_EN   = 3;
  localparam int unsigned OSC_FAIL_IRQ_EN       = 2;
  localparam int unsigned VOLTAGE_DETECT_IRQ_EN = 1;
  localparam int unsigned SOFTWARE_IRQ_EN       = 0;
  localparam int unsigned EXT_PIN0_IRQ_EN       = 0;
  localparam int unsigned DMA1_ABORT_IRQ_EN     = 3;
  localparam int unsigned TIMER0_IRQ_EN         = 7;
  localparam int unsigned UART1_IRQ_EN          = 6;
  localparam int unsigned I2C1_IRQ_EN           = 1;
  localparam int unsigned UNIMPL_BIT            = 4;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Implemented bits and reset values.
  localparam logic [REG_W-1:0] FULL_MASK        = 8'hFF;
  localparam logic [REG_W-1:0] LOGIC_TIMER_MASK = 8'hEF;
  localparam ieb_bank_t IMPL_MASK = {FULL_MASK, FULL_MASK, LOGIC_TIMER_MASK, FULL_MASK,
                                     FULL_MASK, FULL_MASK, FULL_MASK};
  localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [REG_W-1:0] FLAG_RESET   = 8'h00;
  localparam logic [REG_W-1:0] READ_IDLE    = 8'h00;
  localparam ieb_bank_t ENABLE_BANK_RESET = {NUM_REGS{ENABLE_RESET}};
  localparam ieb_bank_t FLAG_BANK_RESET   = {NUM_REGS{FLAG_RESET}};

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Carriers and module state.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } ieb_bus_req_t;

  typedef struct packed {
    ieb_bank_t        en;
    logic [REG_W-1:0] rd_data;
    logic             started;
  } ieb_ctrl_st_t;

  typedef struct packed {
    ieb_bank_t flag;
  } ieb_flag_st_t;

  typedef struct packed {
    ieb_bank_t req;
    logic      irq;
  } ieb_gate_st_t;

  // One-hot select of the register that an address hits within a bank of seven.
  function automatic ieb_sel_t ieb_decode(input logic [ADDR_W-1:0] addr,
                                          input logic [ADDR_W-1:0] base);
    ieb_sel_t sel;
    sel = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (addr == base + ADDR_W'(i))
      begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction : ieb_decode

endpackage : ieb_pkg

// ### logic/ieb_flag_bank.sv
// Sticky source flags: set by peripheral events, cleared by software write-one.
`timescale 1ns/1ps
module ieb_flag_bank
  import ieb_pkg::*;
(
  input  logic                 clk,
  input  logic                 rst_n,
  input  ieb_pkg::ieb_bank_t   set_bank,
  input  ieb_pkg::ieb_bank_t   clr_bank,
  output ieb_pkg::ieb_bank_t   flags
);

  ieb_flag_st_t st;
  ieb_flag_st_t next_st;

  // The set term is applied after the clear so an event in the clearing cycle is kept.
  always_comb
  begin
    next_st      = st;
    next_st.flag = ((st.flag & ~clr_bank) | set_bank) & IMPL_MASK;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.flag <= FLAG_BANK_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign flags = st.flag;

endmodule : ieb_flag_bank

// ### logic/ieb_req_gate.sv
// Request gating: each flag passes only under its enable; all of them merge into one line.
`timescale 1ns/1ps
module ieb_req_gate
  import ieb_pkg::*;
(
  input  logic                 clk,
  input  logic                 rst_n,
  input  ieb_pkg::ieb_bank_t   flags,
  input  ieb_pkg::ieb_bank_t   enables,
  output ieb_pkg::ieb_bank_t   req,
  output logic                 irq
);

  ieb_gate_st_t st;
  ieb_gate_st_t next_st;

  always_comb
  begin
    next_st     = st;
    next_st.req = flags & enables;
    next_st.irq = |(flags & enables);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign req = st.req;
  assign irq = st.irq;

endmodule : ieb_req_gate

// ### logic/ieb_irq_enable_bank.sv
// Top of the interrupt enable bank: register port, enable storage, flags and request gating.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module ieb_irq_enable_bank
  import ieb_pkg::*;
(
  input  logic                       SYS_CLK,
  input  logic                       RST_N,
  input  ieb_pkg::ieb_bus_req_t      BUS_REQ,
  output logic [ieb_pkg::REG_W-1:0]  RD_DATA,
  input  ieb_pkg::ieb_bank_t         PERIPH_EVENT,
  output ieb_pkg::ieb_bank_t         IRQ_REQ,
  output logic                       IRQ
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State and internal nets.

  ieb_ctrl_st_t     st;
  ieb_ctrl_st_t     next_st;
  ieb_sel_t         sel_en;
  ieb_sel_t         sel_flag;
  ieb_sel_t         sel_pend;
  ieb_bank_t        flags;
  ieb_bank_t        pending;
  ieb_bank_t        clr_bank;
  ieb_bank_t        event_bank;
  logic [REG_W-1:0] read_value;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  always_comb
  begin
    sel_en   = ieb_decode(BUS_REQ.addr, ENABLE_BASE);
    sel_flag = ieb_decode(BUS_REQ.addr, FLAG_BASE);
    sel_pend = ieb_decode(BUS_REQ.addr, PENDING_BASE);
  end

  // Events at unimplemented positions never reach a flag.
  always_comb
  begin
    event_bank = PERIPH_EVENT & IMPL_MASK;
    pending    = flags & st.en;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Write-one-to-clear of the flags.

  always_comb
  begin
    clr_bank = '0;
    if (BUS_REQ.wr)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (sel_flag[i])
        begin
          clr_bank[i] = BUS_REQ.wdata & IMPL_MASK[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; an unmapped address reads as zero.

  always_comb
  begin
    read_value = READ_IDLE;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (sel_en[i])
      begin
        read_value = st.en[i];
      end
      if (sel_flag[i])
      begin
        read_value = flags[i];
      end
      if (sel_pend[i])
      begin
        read_value = pending[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Enable storage and read data register.

  always_comb
  begin
    next_st         = st;
    next_st.rd_data = READ_IDLE;
    next_st.started = 1'b1;
    if (BUS_REQ.wr)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (sel_en[i])
        begin
          // Masking here keeps unimplemented bits at zero for good.
          next_st.en[i] = BUS_REQ.wdata & IMPL_MASK[i];
        end
      end
    end
    if (BUS_REQ.rd)
    begin
      next_st.rd_data = read_value;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st.en      <= ENABLE_BANK_RESET;
      st.rd_data <= READ_IDLE;
      st.started <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign RD_DATA = st.rd_data;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Flags and request gating.

  ieb_flag_bank u_flags
  (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .set_bank (event_bank),
    .clr_bank (clr_bank),
    .flags    (flags)
  );

  // The gate adds one cycle so that the request lines leave from flip-flops.
  ieb_req_gate u_gate
  (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .flags   (flags),
    .enables (st.en),
    .req     (IRQ_REQ),
    .irq     (IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge SYS_CLK);
  endclocking

  default disable iff (!RST_N);

  sequence s_timer_en_write;
    BUS_REQ.wr && sel_en[LOGIC_TIMER_IDX];
  endsequence

  sequence s_same_addr_read;
    BUS_REQ.rd && (BUS_REQ.addr == $past(BUS_REQ.addr));
  endsequence

  sequence s_flag_clear_no_event;
    BUS_REQ.wr && (sel_flag != '0) && (PERIPH_EVENT == '0);
  endsequence

  // A clear and an event that hit the same bit in one cycle.
  sequence s_event_meets_clear;
    BUS_REQ.wr && ((clr_bank & event_bank) != '0);
  endsequence

  sequence s_no_flag_write;
    !(BUS_REQ.wr && (sel_flag != '0));
  endsequence

  sequence s_no_enable_write;
    !(BUS_REQ.wr && (sel_en != '0));
  endsequence

  a_event_sets_flag :
    assert property (1'b1 |=> ((flags & $past(event_bank)) == $past(event_bank)))
    else $error("peripheral event did not set its flag");

  a_flag_is_sticky :
    assert property (1'b1 |=> ((~flags & $past(flags & ~clr_bank)) == '0))
    else $error("flag dropped without a software clear");

  a_flag_clear_works :
    assert property (s_flag_clear_no_event |=> ((flags & $past(clr_bank)) == '0))
    else $error("write of one did not clear the flag");

  a_enable_reset_zero :
    assert property (!st.started |-> (st.en == ENABLE_BANK_RESET))
    else $error("enable bank not zero after reset");

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_en_chk
      a_enable_write :
        assert property (BUS_REQ.wr && sel_en[g]
                         |=> st.en[g] == ($past(BUS_REQ.wdata) & IMPL_MASK[g]))
        else $error("enable register did not take the written value");

      // Each register class is traced through the read multiplexer on its own.
      a_enable_read :
        assert property (BUS_REQ.rd && sel_en[g] |=> RD_DATA == $past(st.en[g]))
        else $error("enable register read returned the wrong value");

      a_flag_read :
        assert property (BUS_REQ.rd && sel_flag[g] |=> RD_DATA == $past(flags[g]))
        else $error("flag register read returned the wrong value");

      a_pending_read :
        assert property (BUS_REQ.rd && sel_pend[g]
                         |=> RD_DATA == $past(flags[g] & st.en[g]))
        else $error("pending register read returned the wrong value");
    end
  endgenerate

  a_timer_readback :
    assert property (s_timer_en_write ##1 s_same_addr_read
                     |=> RD_DATA == ($past(BUS_REQ.wdata, 2) & LOGIC_TIMER_MASK))
    else $error("read back of timer enable register is wrong");

  a_unimpl_zero :
    assert property (st.en[LOGIC_TIMER_IDX][UNIMPL_BIT] == 1'b0
                     && flags[LOGIC_TIMER_IDX][UNIMPL_BIT] == 1'b0)
    else $error("unimplemented bit holds a one");

  a_request_gated :
    assert property (1'b1 |=> IRQ_REQ == $past(flags & st.en))
    else $error("forwarded request does not match flag and enable");

  a_irq_level :
    assert property (1'b1 |=> IRQ == $past(|(flags & st.en)))
    else $error("interrupt line does not match enabled flags");

  a_read_idle_zero :
    assert property (!BUS_REQ.rd |=> RD_DATA == READ_IDLE)
    else $error("read data not zero outside a read answer");

  a_unmapped_read :
    assert property (BUS_REQ.rd && (sel_en == '0) && (sel_flag == '0) && (sel_pend == '0)
                     |=> RD_DATA == READ_IDLE)
    else $error("unmapped read returned nonzero data");

  // Losing an event to a clear in the same cycle would hide a request for good.
  a_set_beats_clear :
    assert property (s_event_meets_clear |=> ((~flags & $past(clr_bank & event_bank)) == '0))
    else $error("clear in the event cycle dropped the new flag");

  a_flag_no_spurious :
    assert property (1'b1 |=> ((flags & ~$past(flags) & ~$past(event_bank)) == '0))
    else $error("flag set without a peripheral event");

  a_clear_needs_write :
    assert property (s_no_flag_write |-> (clr_bank == '0))
    else $error("flag clear raised without a write to a flag register");

  a_enable_holds :
    assert property (s_no_enable_write |=> (st.en == $past(st.en)))
    else $error("enable bank changed without a write");

  a_irq_any_req :
    assert property (IRQ == (IRQ_REQ != '0))
    else $error("interrupt line disagrees with the request lines");

  a_reset_outputs_quiet :
    assert property (!st.started |-> (!IRQ && (IRQ_REQ == '0) && (RD_DATA == READ_IDLE)))
    else $error("outputs not quiet in the first cycle after reset");

endmodule : ieb_irq_enable_bank

// ### testbench/ieb_irq_enable_bank_tb.sv
// Self-checking bench of the interrupt enable bank: register port, flags and request line.
`timescale 1ns/1ps
module ieb_irq_enable_bank_tb;
  import ieb_pkg::*;

  localparam int TIMEOUT = 2000;

  logic             sys_clk;
  logic             rst_n;
  ieb_bus_req_t     bus_req;
  logic [REG_W-1:0] rd_data;
  ieb_bank_t        periph_event;
  ieb_bank_t        irq_req;
  logic             irq;
  int               miscompares = 0;
  int               n_compared = 0;
  int               cycles = 0;
  logic [REG_W-1:0] bm;

  ieb_irq_enable_bank ieb_irq_enable_bank_inst
  (
    .SYS_CLK      (sys_clk),
    .RST_N        (rst_n),
    .BUS_REQ      (bus_req),
    .RD_DATA      (rd_data),
    .PERIPH_EVENT (periph_event),
    .IRQ_REQ      (irq_req),
    .IRQ          (irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [REG_W-1:0] act, input logic [REG_W-1:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h, expected %h", $time, act, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(rd_data, exp);
  endtask : rd_chk

  // Write and read on the same address with no idle cycle between the strobes.
  task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
                           input logic [REG_W-1:0] exp);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(rd_data, exp);
  endtask : wr_rd_chk

  task automatic pulse(input int i, input int b);
    ieb_bank_t ev;
    ev = '0;
    ev[i][b] = 1'b1;
    @(posedge sys_clk);
    periph_event <= ev;
    @(posedge sys_clk);
    periph_event <= '0;
  endtask : pulse

  // A flag clear and a new event on the same bit in one cycle.
  task automatic clr_with_event(input int i, input int b);
    ieb_bank_t ev;
    ev = '0;
    ev[i][b] = 1'b1;
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: FLAG_BASE + ADDR_W'(i), wdata: ev[i]};
    periph_event <= ev;
    @(posedge sys_clk);
    bus_req <= '0;
    periph_event <= '0;
  endtask : clr_with_event

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  function automatic logic [REG_W-1:0] impl(input int i);
    return (i == LOGIC_TIMER_IDX) ? 8'hEF : 8'hFF;
  endfunction : impl

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT)
    begin
      $display("ERROR at %0t: run did not finish in time", $time);
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    periph_event = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      rd_chk(ENABLE_BASE + ADDR_W'(i), 8'h00);
      rd_chk(FLAG_BASE + ADDR_W'(i), 8'h00);
      wr_reg(ENABLE_BASE + ADDR_W'(i), 8'hFF);
      rd_chk(ENABLE_BASE + ADDR_W'(i), impl(i));
      wr_reg(ENABLE_BASE + ADDR_W'(i), 8'h5A);
      rd_chk(ENABLE_BASE + ADDR_W'(i), 8'h5A & impl(i));
      wr_reg(ENABLE_BASE + ADDR_W'(i), 8'h00);
      rd_chk(ENABLE_BASE + ADDR_W'(i), 8'h00);
    end
    // Unmapped places neither store nor return anything.
    wr_reg(8'h07, 8'hFF);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h30, 8'h00);
    rd_chk(ENABLE_BASE, 8'h00);
    wr_rd_chk(ENABLE_BASE + ADDR_W'(LOGIC_TIMER_IDX), 8'hFF, 8'hEF);
    wr_rd_chk(ENABLE_BASE + ADDR_W'(LOGIC_TIMER_IDX), 8'h00, 8'h00);
    // The event must win over a clear that lands in the same cycle.
    clr_with_event(TIMER0_UART1_IDX, TIMER0_IRQ_EN);
    rd_chk(FLAG_BASE + ADDR_W'(TIMER0_UART1_IDX), 8'h80);
    wr_reg(FLAG_BASE + ADDR_W'(TIMER0_UART1_IDX), 8'h80);
    rd_chk(FLAG_BASE + ADDR_W'(TIMER0_UART1_IDX), 8'h00);
    // One source per register: flag sets while masked, request appears only once enabled.
    for (int i = 0; i < NUM_REGS; i++)
    begin
      bm = 8'h01 << ((i + 1) % 8);
      pulse(i, (i + 1) % 8);
      settle();
      chk({7'h00, irq}, 8'h00);
      rd_chk(FLAG_BASE + ADDR_W'(i), bm);
      rd_chk(PENDING_BASE + ADDR_W'(i), 8'h00);
      wr_reg(ENABLE_BASE + ADDR_W'(i), bm);
      settle();
      chk({7'h00, irq}, 8'h01);
      chk(irq_req[i], bm);
      rd_chk(PENDING_BASE + ADDR_W'(i), bm);
      wr_reg(ENABLE_BASE + ADDR_W'(i), 8'h00);
      settle();
      chk({7'h00, irq}, 8'h00);
      rd_chk(FLAG_BASE + ADDR_W'(i), bm);
      wr_reg(FLAG_BASE + ADDR_W'(i), bm);
      rd_chk(FLAG_BASE + ADDR_W'(i), 8'h00);
    end
    pulse(LOGIC_TIMER_IDX, UNIMPL_BIT);
    rd_chk(FLAG_BASE + ADDR_W'(LOGIC_TIMER_IDX), 8'h00);
    // A reset in mid-run must drop a live request and every enable of its register.
    wr_reg(FLAG_BASE + ADDR_W'(SERIAL_DMA1_IDX), 8'hFF);
    wr_reg(ENABLE_BASE + ADDR_W'(SERIAL_DMA1_IDX), 8'hFF);
    pulse(SERIAL_DMA1_IDX, DMA1_ABORT_IRQ_EN);
    settle();
    chk({7'h00, irq}, 8'h01);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({7'h00, irq}, 8'h00);
    rd_chk(ENABLE_BASE + ADDR_W'(SERIAL_DMA1_IDX), 8'h00);
    rd_chk(FLAG_BASE + ADDR_W'(SERIAL_DMA1_IDX), 8'h00);
    give_verdict();
  end

endmodule : ieb_irq_enable_bank_tb
